// [common/pdvc_pkg.sv]
// constants, field layout and types for the divider and vco calibration block
// assumes a byte-wide register port and a single 40 MHz device clock
package pdvc_pkg;

  localparam int          NUM_CH       = 14;
  localparam int          CAL_PERIODS  = 400000;   // pfd periods per calibration
  localparam logic [10:0] CAL_PRESCALE = 11'h004;  // fixed dual-modulus value

  // register offsets
  localparam logic [15:0] A_XFER   = 16'h000F;
  localparam logic [15:0] A_N2     = 16'h0201;
  localparam logic [15:0] A_CAL    = 16'h0203;
  localparam logic [15:0] A_CALAB  = 16'h0204;
  localparam logic [15:0] A_M1     = 16'h0207;
  localparam logic [15:0] A_DBL    = 16'h0208;
  localparam logic [15:0] A_SYNC   = 16'h032A;
  localparam logic [15:0] A_STATUS = 16'h0509;
  localparam logic [15:0] A_CH_DIV = 16'h0300;
  localparam logic [15:0] A_CH_CFG = 16'h0310;

  // field positions
  localparam int XFER_BIT  = 0;
  localparam int CAL_BIT   = 0;
  localparam int SYNC_BIT  = 0;
  localparam int DBL_BIT   = 0;
  localparam int ST_BUSY   = 0;
  localparam int ST_MATCH  = 1;
  localparam int ST_FIRST  = 2;
  localparam int CALB_LSB  = 0;
  localparam int CALA_LSB  = 6;
  localparam int M1_LSB    = 0;
  localparam int SRC_LSB   = 0;
  localparam int IGN_BIT   = 2;

  // reset values
  localparam logic [7:0] N2_RST     = 8'h0A;
  localparam logic [7:0] CALAB_RST  = 8'h87;
  localparam logic [7:0] M1_RST     = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] CH_DIV_RST = 8'h03;
  localparam logic [7:0] CH_CFG_RST = 8'h01;

  // channel sources
  localparam logic [1:0] SRC_REF    = 2'h0;
  localparam logic [1:0] SRC_RF     = 2'h1;
  localparam logic [1:0] SRC_SYSREF = 2'h2;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_DONE = 2'b10
  } pdvc_cal_state_t;

  // vco rf divider select code to ratio
  function automatic logic [2:0] pdvc_m1_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    pdvc_m1_ratio = 3'h3;
      2'h1:    pdvc_m1_ratio = 3'h4;
      default: pdvc_m1_ratio = 3'h5;
    endcase
  endfunction : pdvc_m1_ratio

endpackage : pdvc_pkg

// [rtl/pdvc_cal_seq.sv]
// vco calibration sequencer: runs a fixed count of pfd periods per start
// assumes start and pfd_tick are one-cycle pulses in the clk domain
`timescale 1ns/1ps
module pdvc_cal_seq
  import pdvc_pkg::*;
#(
  parameter int PERIODS = CAL_PERIODS
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic pfd_tick,
  output logic      busy,
  output logic      done,
  output logic      cal_path
);

  localparam int CW = $clog2(PERIODS + 1);

  pdvc_cal_state_t state_q;
  pdvc_cal_state_t state_d;
  logic [CW-1:0]   cnt_q;

  wire last = pfd_tick && (cnt_q == CW'(PERIODS - 1));

  ////////////////////////////////////////////////////////////////////////
  // next state; a start while running is dropped, not queued
  always_comb begin
    state_d = state_q;
    case (state_q)
      CAL_IDLE: if (start) state_d = CAL_RUN;
      CAL_RUN:  if (last) state_d = CAL_DONE;
      CAL_DONE: state_d = CAL_IDLE;
      default:  state_d = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CAL_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q != CAL_RUN) cnt_q <= '0;
      else if (pfd_tick) cnt_q <= cnt_q + 1'b1;
    end
  end

  assign busy     = (state_q == CAL_RUN);
  assign done     = (state_q == CAL_DONE);
  assign cal_path = busy;

  ////////////////////////////////////////////////////////////////////////
  a_cal_run_starts: assert property (@(posedge clk) disable iff (!reset_n)
    (start && state_q == CAL_IDLE) |=> busy)
    else $error("calibration did not start");

  a_cal_done_reverts: assert property (@(posedge clk) disable iff (!reset_n)
    done |-> $past(busy) && !cal_path ##1 !cal_path)
    else $error("calibration path not released after finish");

endmodule : pdvc_cal_seq

// [rtl/pdvc_chan_div.sv]
// one output channel divider with duty-cycle correction and sysref retiming
// assumes tick and half are one-cycle enables from the selected source
`timescale 1ns/1ps
module pdvc_chan_div
  import pdvc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       tick,
  input  wire logic       half,
  input  wire logic [7:0] ratio,
  input  wire logic       use_sysref,
  input  wire logic       sysref_in,
  input  wire logic       hold,
  output logic            clk_out
);

  logic [7:0] ratio_q;
  logic [7:0] cnt_q;
  logic       div_q;
  logic       sr_q;
  logic       div_d;

  wire [8:0] divide   = {1'b0, ratio_q} + 9'h001;
  wire [8:0] hi_ticks = (divide + 9'h001) >> 1;
  wire       wrap     = (cnt_q == ratio_q);
  wire [7:0] cnt_next = wrap ? 8'h00 : cnt_q + 8'h01;
  wire       rise     = tick && wrap;
  wire       sr_d     = rise ? sysref_in : sr_q;

  ////////////////////////////////////////////////////////////////////////
  // odd divides (even ratio values) fall on the half point of the middle input period
  always_comb begin
    div_d = div_q;
    if (tick) div_d = ({1'b0, cnt_next} < hi_ticks);
    else if (half && divide[0] && ({1'b0, cnt_q} == hi_ticks - 9'h001)) div_d = 1'b0;
  end

  // hold parks the counter so the first tick after release starts a period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ratio_q <= CH_DIV_RST;
      cnt_q   <= CH_DIV_RST;
      div_q   <= 1'b0;
      sr_q    <= 1'b0;
      clk_out <= 1'b0;
    end else if (hold) begin
      ratio_q <= ratio;        // new ratio takes effect only through a sync
      cnt_q   <= ratio;
      div_q   <= 1'b0;
      sr_q    <= 1'b0;
      clk_out <= 1'b0;
    end else begin
      if (tick) cnt_q <= cnt_next;
      div_q   <= div_d;
      sr_q    <= sr_d;
      clk_out <= use_sysref ? sr_d : div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_hold_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    hold |=> !clk_out && cnt_q == $past(ratio))
    else $error("held divider not reset");

  a_odd_half_fall: assert property (@(posedge clk) disable iff (!reset_n)
    (half && !tick && !hold && !use_sysref && divide[0] && ({1'b0, cnt_q} == hi_ticks - 9'h001))
    |=> !clk_out)
    else $error("odd divide missed its half-period fall");

  a_count_range: assert property (@(posedge clk) disable iff (!reset_n)
    (tick && !hold) |=> cnt_q <= ratio_q)
    else $error("divider count beyond ratio");

endmodule : pdvc_chan_div

// [rtl/pdvc_top.sv]
// high-frequency loop feedback dividers, vco calibration control and the
// fourteen output channel dividers with their synchronisation
// assumes a byte register port, pfd and vcxo enables synchronous to clk
`timescale 1ns/1ps
module pdvc_top
  import pdvc_pkg::*;
#(
  parameter int CAL_PFD_PERIODS = CAL_PERIODS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        pfd_tick,
  input  wire logic        vcxo_tick,
  input  wire logic        sysref_in,
  output logic             fb_path_cal,
  output logic      [10:0] fb_divide,
  output logic             doubler_en,
  output logic      [13:0] chan_out
);

  ////////////////////////////////////////////////////////////////////////
  // written copies and the copies that the logic uses
  logic [7:0] n2_w_q, calab_w_q, m1_w_q, dbl_w_q, cal_w_q, sync_w_q;
  logic [7:0] n2_q, calab_q, m1_q, dbl_q, cal_q, sync_q;
  logic [7:0] ch_div_q [NUM_CH];
  logic [7:0] ch_cfg_q [NUM_CH];
  logic       cal_prev_q;
  logic       sync_prev_q;
  logic       first_done_q;
  logic       auto_sync_q;
  logic [2:0] rf_cnt_q;
  logic [7:0] rd_mux;
  logic       cal_busy;
  logic       cal_done;
  logic       cal_path;

  // address decode
  wire hit_xfer  = (reg_addr == A_XFER);
  wire hit_n2    = (reg_addr == A_N2);
  wire hit_cal   = (reg_addr == A_CAL);
  wire hit_calab = (reg_addr == A_CALAB);
  wire hit_m1    = (reg_addr == A_M1);
  wire hit_dbl   = (reg_addr == A_DBL);
  wire hit_sync  = (reg_addr == A_SYNC);
  wire hit_stat  = (reg_addr == A_STATUS);
  wire hit_div   = (reg_addr[15:4] == A_CH_DIV[15:4]) && (reg_addr[3:0] < 4'hE);
  wire hit_cfg   = (reg_addr[15:4] == A_CH_CFG[15:4]) && (reg_addr[3:0] < 4'hE);
  wire [3:0] ch_idx = reg_addr[3:0];

  // transfer strobe copies written values into the working set
  wire xfer = reg_wr && hit_xfer && reg_wdata[XFER_BIT];

  ////////////////////////////////////////////////////////////////////////
  // feedback divide values
  wire [2:0]  m1_ratio  = pdvc_m1_ratio(m1_q[M1_LSB +: 2]);
  wire [10:0] norm_div  = {3'h0, n2_q} * {8'h00, m1_ratio};
  wire [10:0] cal_div   = CAL_PRESCALE * {5'h00, calab_q[CALB_LSB +: 6]}
                        + {9'h000, calab_q[CALA_LSB +: 2]};
  wire        div_match = (norm_div == cal_div);

  // calibration start on a fresh rising edge only
  wire cal_start = cal_q[CAL_BIT] && !cal_prev_q;

  // sync control: level disables, falling edge is the sync event
  wire sync_act   = sync_q[SYNC_BIT];
  wire sync_event = sync_prev_q && !sync_act;

  // stand-in for the vco rf divider output, half point for duty correction
  wire [2:0] rf_last = m1_ratio - 3'h1;
  wire       rf_tick = (rf_cnt_q == 3'h0);
  wire       rf_half = (rf_cnt_q == (m1_ratio >> 1));

  ////////////////////////////////////////////////////////////////////////
  // register writes; written copies read back before the transfer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      n2_w_q    <= N2_RST;
      calab_w_q <= CALAB_RST;
      m1_w_q    <= M1_RST;
      dbl_w_q   <= CTRL_RST;
      cal_w_q   <= CTRL_RST;
      sync_w_q  <= CTRL_RST;
    end else if (reg_wr) begin
      if (hit_n2)    n2_w_q    <= reg_wdata;
      if (hit_calab) calab_w_q <= reg_wdata;
      if (hit_m1)    m1_w_q    <= reg_wdata;
      if (hit_dbl)   dbl_w_q   <= reg_wdata;
      if (hit_cal)   cal_w_q   <= reg_wdata;
      if (hit_sync)  sync_w_q  <= reg_wdata;
    end
  end

  // working set moves only on the transfer strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      n2_q    <= N2_RST;
      calab_q <= CALAB_RST;
      m1_q    <= M1_RST;
      dbl_q   <= CTRL_RST;
      cal_q   <= CTRL_RST;
      sync_q  <= CTRL_RST;
    end else if (xfer) begin
      n2_q    <= n2_w_q;
      calab_q <= calab_w_q;
      m1_q    <= m1_w_q;
      dbl_q   <= dbl_w_q;
      cal_q   <= cal_w_q;
      sync_q  <= sync_w_q;
    end
  end

  // channel settings act directly; ratios still wait for a sync to load
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_div_q[i] <= CH_DIV_RST;
        ch_cfg_q[i] <= CH_CFG_RST;
      end
    end else if (reg_wr) begin
      if (hit_div) ch_div_q[ch_idx] <= reg_wdata;
      if (hit_cfg) ch_cfg_q[ch_idx] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses and the strobe read as zero
  always_comb begin
    rd_mux = 8'h00;
    if (hit_n2)    rd_mux = n2_w_q;
    if (hit_calab) rd_mux = calab_w_q;
    if (hit_m1)    rd_mux = m1_w_q;
    if (hit_dbl)   rd_mux = dbl_w_q;
    if (hit_cal)   rd_mux = cal_w_q;
    if (hit_sync)  rd_mux = sync_w_q;
    if (hit_div)   rd_mux = ch_div_q[ch_idx];
    if (hit_cfg)   rd_mux = ch_cfg_q[ch_idx];
    if (hit_stat) begin
      rd_mux[ST_BUSY]  = cal_busy;
      rd_mux[ST_MATCH] = div_match;
      rd_mux[ST_FIRST] = first_done_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge history, first-calibration tracking and rf divider counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_prev_q   <= 1'b0;
      sync_prev_q  <= 1'b0;
      first_done_q <= 1'b0;
      auto_sync_q  <= 1'b0;
      rf_cnt_q     <= 3'h0;
    end else begin
      cal_prev_q  <= cal_q[CAL_BIT];
      sync_prev_q <= sync_act;
      auto_sync_q <= cal_done && !first_done_q;
      if (cal_done) first_done_q <= 1'b1;
      rf_cnt_q <= (rf_cnt_q >= rf_last) ? 3'h0 : rf_cnt_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // calibration sequencer
  pdvc_cal_seq #(
    .PERIODS (CAL_PFD_PERIODS)
  ) u_cal (
    .clk      (clk),
    .reset_n  (reset_n),
    .start    (cal_start),
    .pfd_tick (pfd_tick),
    .busy     (cal_busy),
    .done     (cal_done),
    .cal_path (cal_path)
  );

  // feedback outputs from flops; path swap is confined to calibration
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fb_path_cal <= 1'b0;
      fb_divide   <= 11'h000;
      doubler_en  <= 1'b0;
    end else begin
      fb_path_cal <= cal_path;
      fb_divide   <= cal_path ? cal_div : norm_div;
      doubler_en  <= dbl_q[DBL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channels; rf-fed ones stay parked until the first calibration ends
  logic [13:0] rf_mask;
  logic [13:0] ign_mask;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    wire [1:0] src    = ch_cfg_q[g][SRC_LSB +: 2];
    wire       is_ref = (src == SRC_REF);
    wire       hold   = (!ch_cfg_q[g][IGN_BIT] && (sync_act || sync_event || auto_sync_q))
                      || (!is_ref && !first_done_q);
    assign rf_mask[g]  = !is_ref;
    assign ign_mask[g] = ch_cfg_q[g][IGN_BIT];

    pdvc_chan_div u_div (
      .clk        (clk),
      .reset_n    (reset_n),
      .tick       (is_ref ? vcxo_tick : rf_tick),
      .half       (is_ref ? 1'b0 : rf_half),
      .ratio      (ch_div_q[g]),
      .use_sysref (src == SRC_SYSREF),
      .sysref_in  (sysref_in),
      .hold       (hold),
      .clk_out    (chan_out[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  a_fb_normal: assert property (@(posedge clk) disable iff (!reset_n)
    !cal_path |=> fb_divide == $past(norm_div) && !fb_path_cal)
    else $error("normal feedback divide is not the product");

  a_fb_cal_sum: assert property (@(posedge clk) disable iff (!reset_n)
    cal_path |=> fb_divide == 11'h004 * {5'h00, $past(calab_q[5:0])}
                 + {9'h000, $past(calab_q[7:6])})
    else $error("calibration divide is not prescale times B plus A");

  a_rf_ratio: assert property (@(posedge clk) disable iff (!reset_n)
    m1_ratio >= 3'h3 && m1_ratio <= 3'h5)
    else $error("vco rf ratio out of range");

  a_cal_edge_only: assert property (@(posedge clk) disable iff (!reset_n)
    (cal_q[CAL_BIT] && $past(cal_q[CAL_BIT]) && !cal_busy) |=> !cal_busy)
    else $error("held calibrate level restarted calibration");

  a_cal_start_busy: assert property (@(posedge clk) disable iff (!reset_n)
    cal_start |=> cal_busy)
    else $error("calibrate edge did not start calibration");

  a_status_busy: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_rd && hit_stat) |=> reg_rvalid && reg_rdata[0] == $past(cal_busy))
    else $error("busy flag readback wrong");

  a_first_autosync: assert property (@(posedge clk) disable iff (!reset_n)
    (cal_done && !first_done_q) |=> auto_sync_q && first_done_q ##1 !auto_sync_q)
    else $error("first calibration did not sync outputs");

  a_rf_held_precal: assert property (@(posedge clk) disable iff (!reset_n)
    !first_done_q |=> (chan_out & $past(rf_mask)) == 14'h0000)
    else $error("rf channel active before first calibration");

  a_sync_disables: assert property (@(posedge clk) disable iff (!reset_n)
    sync_act |=> (chan_out & ~$past(ign_mask)) == 14'h0000)
    else $error("output active while sync is set");

  ////////////////////////////////////////////////////////////////////////
  // register port, transfer, channel release, calibration path and rf tick checks
  a_sync_event_hold: assert property (@(posedge clk) disable iff (!reset_n)
    sync_event |=> (chan_out & ~$past(ign_mask)) == 14'h0000)
    else $error("sync release did not reset the dividers");

  a_xfer_loads: assert property (@(posedge clk) disable iff (!reset_n)
    xfer |=> cal_q == $past(cal_w_q) && n2_q == $past(n2_w_q)
             && calab_q == $past(calab_w_q) && m1_q == $past(m1_w_q))
    else $error("transfer strobe did not move the staged settings");

  a_staged_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !xfer |=> $stable(cal_q) && $stable(calab_q) && $stable(sync_q))
    else $error("working setting moved without a transfer");

  a_cal_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr && hit_cal) |=> cal_w_q == $past(reg_wdata))
    else $error("calibrate register write lost");

  a_read_answer: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after the request");

  a_status_fields: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_rd && hit_stat) |=> reg_rdata[ST_FIRST] == $past(first_done_q)
                             && reg_rdata[ST_MATCH] == $past(div_match))
    else $error("status readback fields wrong");

  a_first_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    first_done_q |=> first_done_q)
    else $error("first calibration record lost");

  a_auto_sync_once: assert property (@(posedge clk) disable iff (!reset_n)
    (cal_done && first_done_q) |=> !auto_sync_q)
    else $error("later calibration synced outputs by itself");

  a_path_follows: assert property (@(posedge clk) disable iff (!reset_n)
    cal_done |=> !fb_path_cal ##1 !fb_path_cal)
    else $error("feedback path stayed on calibration after finish");

  a_path_only_cal: assert property (@(posedge clk) disable iff (!reset_n)
    fb_path_cal |-> $past(cal_busy))
    else $error("calibration path selected outside calibration");

  a_rf_tick_period: assert property (@(posedge clk) disable iff (!reset_n)
    rf_tick |=> !rf_tick ##1 !rf_tick)
    else $error("rf divider tick faster than divide by three");

endmodule : pdvc_top

// [tb/pdvc_host.sv]
// host model: byte register master plus pfd, vcxo and sysref stimulus
// assumes the register port of the divider block and a free running clk
`timescale 1ns/1ps
module pdvc_host (
  input  wire logic        clk,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        reg_rvalid,
  output logic      [15:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic             pfd_tick,
  output logic             vcxo_tick,
  output logic             sysref_in
);
  logic [7:0] cnt_q;

  // idle bus at time zero so nothing is taken during reset
  initial begin
    reg_addr  = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    cnt_q     = 8'h00;
    pfd_tick  = 1'b0;
    vcxo_tick = 1'b0;
    sysref_in = 1'b0;
  end

  // reference and pfd enables run before any calibration is asked for
  always @(posedge clk) begin
    cnt_q     <= cnt_q + 8'h01;
    pfd_tick  <= (cnt_q[1:0] == 2'h3);
    vcxo_tick <= (cnt_q[2:0] == 3'h7);
    sysref_in <= cnt_q[7];
  end

  ////////////////////////////////////////////////////////////////////////////
  // one write; strobe stands for a single edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // settings are staged first, the strobe moves them in together
  task automatic xfer();
    wr(16'h000F, 8'h01);
  endtask : xfer

  // one read; answer awaited a bounded number of cycles
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        d  = reg_rdata;
        ok = 1'b1;
      end else begin
        @(posedge clk);
      end
    end
  endtask : rd
endmodule : pdvc_host

// [tb/pll_divider_vco_calibration_tb.sv]
// testbench: register sequences for calibration, feedback divide and sync
// assumes pdvc_top with a short calibration count and the pdvc_host model
`timescale 1ns/1ps
module pll_divider_vco_calibration_tb
  import pdvc_pkg::*;
;
  logic        clk;
  logic        reset_n;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        pfd_tick;
  logic        vcxo_tick;
  logic        sysref_in;
  logic        fb_path_cal;
  logic [10:0] fb_divide;
  logic        doubler_en;
  logic [13:0] chan_out;
  int          miscompares = 0;
  int          compares    = 0;
  int          m1c[4]      = '{0, 2, 3, 1};
  int          m1r[4]      = '{3, 5, 5, 4};

  pdvc_top #(.CAL_PFD_PERIODS(8)) u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pfd_tick(pfd_tick), .vcxo_tick(vcxo_tick),
    .sysref_in(sysref_in), .fb_path_cal(fb_path_cal), .fb_divide(fb_divide),
    .doubler_en(doubler_en), .chan_out(chan_out));
  pdvc_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .pfd_tick(pfd_tick), .vcxo_tick(vcxo_tick), .sysref_in(sysref_in));

  // 40 MHz device clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // settle after the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    u_host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("FAIL read answer at %h expected 1 seen 0", a);
      conclude();
    end
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
  endtask : rdchk

  // polls busy; a hung calibration ends the run
  task automatic wait_idle();
    logic [7:0] d;
    logic       ok;
    int         n;
    d = 8'h01;
    for (n = 0; n < 40 && d[ST_BUSY] !== 1'b0; n++) begin
      u_host.rd(A_STATUS, d, ok);
      if (ok !== 1'b1) d[ST_BUSY] = 1'b1;   // a missing answer is not idle
    end
    if (d[ST_BUSY] !== 1'b0) begin
      miscompares++;
      $display("FAIL calibration end expected 0 seen 1");
      conclude();
    end
  endtask : wait_idle

  // high and low time of one channel, in clk cycles
  task automatic measure(input int ch, input int hi, input int lo);
    int n;
    int h;
    int l;
    n = 0;
    h = 0;
    l = 0;
    while (chan_out[ch] !== 1'b0 && n < 3000) begin
      cyc(1);
      n++;
    end
    while (chan_out[ch] !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    while (chan_out[ch] === 1'b1 && n < 3000) begin
      cyc(1);
      h++;
      n++;
    end
    while (chan_out[ch] === 1'b0 && n < 3000) begin
      cyc(1);
      l++;
      n++;
    end
    chk($sformatf("ch%0d high", ch), 16'(hi), 16'(h));
    chk($sformatf("ch%0d low", ch), 16'(lo), 16'(l));
  endtask : measure

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    cyc(2);
    // reset values, refused places
    rdchk(A_N2, N2_RST);
    rdchk(A_CALAB, CALAB_RST);
    rdchk(A_M1, M1_RST);
    rdchk(A_XFER, 8'h00);
    rdchk(16'h0100, 8'h00);
    u_host.wr(A_STATUS, 8'hFF);
    rdchk(A_STATUS, 8'h02);
    chk("fb divide", 16'd30, {5'h00, fb_divide});
    chk("held outputs", 16'h0000, {2'h0, chan_out});
    $display("test reset done");
    // first calibration, staged before the strobe
    u_host.wr(A_CAL, 8'h01);
    u_host.xfer();
    cyc(2);
    rdchk(A_STATUS, 8'h03);
    cyc(1);
    chk("cal path", 16'h0001, {15'h0, fb_path_cal});
    chk("cal divide", 16'd30, {5'h00, fb_divide});
    wait_idle();
    cyc(2);
    chk("cal path off", 16'h0000, {15'h0, fb_path_cal});
    measure(1, 6, 6);
    u_host.xfer();
    cyc(3);
    rdchk(A_STATUS, 8'h06);
    rdchk(A_CAL, 8'h01);
    $display("test calibrate done");
    // rf divider codes enter the normal product
    for (int i = 0; i < 4; i++) begin
      u_host.wr(A_M1, 8'(m1c[i]));
      u_host.xfer();
      cyc(2);
      chk("fb divide", 16'(N2_RST * m1r[i]), {5'h00, fb_divide});
    end
    u_host.wr(A_DBL, 8'h01);
    u_host.xfer();
    cyc(2);
    chk("doubler", 16'h0001, {15'h0, doubler_en});
    // recalibrate for the new product: clear, then set again
    u_host.wr(A_CALAB, 8'h0A);
    u_host.wr(A_CAL, 8'h00);
    u_host.xfer();
    u_host.wr(A_CAL, 8'h01);
    u_host.xfer();
    cyc(2);
    rdchk(A_STATUS, 8'h07);
    wait_idle();
    $display("test feedback done");
    // sync with one channel ignoring it
    u_host.wr(A_CH_DIV + 16'h0000, 8'h02);
    u_host.wr(A_CH_DIV + 16'h0001, 8'hFF);
    u_host.wr(A_CH_CFG + 16'h0002, 8'h05);
    u_host.wr(A_CH_CFG + 16'h0003, 8'h00);
    u_host.wr(A_CH_CFG + 16'h0004, 8'h02);
    u_host.wr(A_SYNC, 8'h01);
    u_host.xfer();
    cyc(2);
    measure(2, 8, 8);
    chk("sync hold", 16'h0000, {14'h0, chan_out[1:0]});
    u_host.wr(A_SYNC, 8'h00);
    u_host.xfer();
    measure(0, 6, 6);
    measure(1, 512, 512);
    measure(3, 16, 16);
    measure(4, 128, 128);
    $display("test sync done");
    conclude();
  end
endmodule : pll_divider_vco_calibration_tb
